// file: spcr_consts.vh
// constants for the serial port pcs control register bank
`ifndef SPCR_CONSTS_VH
`define SPCR_CONSTS_VH

// register indexes as printed
`define SPCR_IDX_ADVERT       32'h001F0004
`define SPCR_IDX_EXPANSION    32'h001F0006
`define SPCR_IDX_DIG_CTRL     32'h001F8000
`define SPCR_IDX_AN_CTRL      32'h001F8001
`define SPCR_IDX_AN_STATUS    32'h001F8002

// byte addresses, four bytes per index
`define SPCR_ADDR_ADVERT      (`SPCR_IDX_ADVERT << 2)
`define SPCR_ADDR_EXPANSION   (`SPCR_IDX_EXPANSION << 2)
`define SPCR_ADDR_DIG_CTRL    (`SPCR_IDX_DIG_CTRL << 2)
`define SPCR_ADDR_AN_CTRL     (`SPCR_IDX_AN_CTRL << 2)
`define SPCR_ADDR_AN_STATUS   (`SPCR_IDX_AN_STATUS << 2)

// reset values
`define SPCR_RST_DIG_CTRL     16'h2400
`define SPCR_RST_AN_CTRL      5'h04
`define SPCR_RST_ADVERT       16'h0020

// field positions
`define SPCR_EXP_PAGE_BIT     1
`define SPCR_DIG_LOOP_BIT     14
`define SPCR_DIG_PSAVE_BIT    11
`define SPCR_ANC_LINK_BIT     4
`define SPCR_ANC_ROLE_BIT     3
`define SPCR_ANC_MODE_HI      2
`define SPCR_ANC_MODE_LO      1
`define SPCR_ANC_IRQEN_BIT    0
`define SPCR_STS_CPLT_BIT     0

// pcs mode codes
`define SPCR_MODE_SERDES      2'h0
`define SPCR_MODE_SGMII       2'h2

// code group width
`define SPCR_CODE_W           10

`endif

// file: spcr_sync.v
// two flip-flop synchroniser for levels from outside the clock domain
`timescale 1ns/100ps
module spcr_sync #(
  parameter W = 1
) (
  input  wire         mclk,
  input  wire         rst_n,
  input  wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);

  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule

// file: spcr_sticky.v
// sticky event flag, a set in the clearing cycle wins
`timescale 1ns/100ps
module spcr_sticky (
  input  wire mclk,
  input  wire rst_n,
  input  wire set_i,
  input  wire clr_i,
  output wire flag_o
);

  reg flag_q;
  reg flag_d;

  always @* begin
    flag_d = flag_q;
    if (clr_i) begin
      flag_d = 1'b0;
    end
    if (set_i) begin
      flag_d = 1'b1;
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign flag_o = flag_q;

endmodule

// file: spcr_regs.v
// serial port pcs control and status registers on ahb-lite
`timescale 1ns/100ps
`include "spcr_consts.vh"
module spcr_regs (
  input  wire                    mclk,
  input  wire                    nrst,
  input  wire                    hsel,
  input  wire [31:0]             haddr,
  input  wire [1:0]              htrans,
  input  wire                    hwrite,
  input  wire [2:0]              hsize,
  input  wire [31:0]             hwdata,
  input  wire                    hready,
  output wire                    hreadyout,
  output wire                    hresp,
  output wire [31:0]             hrdata,
  input  wire                    an_page_rx,
  input  wire                    an_done,
  input  wire                    lp_link_up,
  input  wire [1:0]              lp_speed,
  input  wire                    lp_duplex,
  input  wire [`SPCR_CODE_W-1:0] rx_code,
  input  wire [`SPCR_CODE_W-1:0] tx_code_in,
  output wire [`SPCR_CODE_W-1:0] tx_code,
  output wire                    loopback_en,
  output wire                    serdes_rx_en,
  output wire                    serdes_tx_en,
  output wire                    pll_en,
  output wire [1:0]              pcs_mode,
  output wire                    sgmii_mode,
  output wire                    serdes_mode,
  output wire                    phy_side_role,
  output wire                    link_status_set,
  output wire                    an_irq
);

  // reset release
  reg  [1:0]  rst_sync_q;
  wire        rst_n;

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  // partner status from the serdes side
  wire [3:0]  lp_stat_s;

  spcr_sync #(
    .W (4)
  ) u_lp_sync (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .async_in ({lp_link_up, lp_speed, lp_duplex}),
    .sync_out (lp_stat_s)
  );

  // bus state
  reg         hreadyout_q;
  reg  [31:0] hrdata_q;
  reg         wr_pend_q;
  reg         rd_pend_q;
  reg  [31:0] addr_q;
  wire        req_take;
  wire        wr_take;
  wire        rd_take;

  // register state
  reg  [15:0] dig_ctrl_q;
  reg  [4:0]  anc_pend_q;
  reg  [4:0]  anc_act_q;
  reg  [15:0] advert_q;
  reg  [`SPCR_CODE_W-1:0] tx_code_q;
  reg         rx_en_q;
  reg         tx_en_q;
  reg         pll_en_q;
  reg  [1:0]  mode_q;
  reg         sgmii_q;
  reg         serdes_q;
  reg         role_q;
  reg         link_set_q;
  reg         irq_q;

  // flag control
  wire        page_flag;
  wire        cplt_flag;
  wire        page_clr;
  wire        cplt_clr;
  reg  [31:0] rd_mux;

  assign req_take = hsel & htrans[1] & hready;
  assign wr_take  = req_take & hwrite;
  assign rd_take  = req_take & ~hwrite;

  spcr_sticky u_page_flag (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .set_i  (an_page_rx),
    .clr_i  (page_clr),
    .flag_o (page_flag)
  );

  spcr_sticky u_cplt_flag (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .set_i  (an_done),
    .clr_i  (cplt_clr),
    .flag_o (cplt_flag)
  );

  // read clears page flag at the data edge
  assign page_clr = rd_pend_q & (addr_q == `SPCR_ADDR_EXPANSION);
  // write of zero to bit 0 clears complete flag
  assign cplt_clr = wr_pend_q & (addr_q == `SPCR_ADDR_AN_STATUS)
                    & ~hwdata[`SPCR_STS_CPLT_BIT];

  // read data selection
  always @* begin
    rd_mux = 32'h0000_0000;
    case (addr_q)
      `SPCR_ADDR_EXPANSION: begin
        rd_mux[`SPCR_EXP_PAGE_BIT] = page_flag;
      end
      `SPCR_ADDR_DIG_CTRL: begin
        rd_mux[15:0] = dig_ctrl_q;
      end
      `SPCR_ADDR_AN_CTRL: begin
        rd_mux[4:0] = anc_pend_q;
      end
      `SPCR_ADDR_ADVERT: begin
        rd_mux[15:0] = advert_q;
      end
      `SPCR_ADDR_AN_STATUS: begin
        rd_mux[4:1] = lp_stat_s;
        rd_mux[`SPCR_STS_CPLT_BIT] = cplt_flag;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // ahb-lite slave, reads take one wait state
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout_q <= 1'b1;
      hrdata_q    <= 32'h0000_0000;
      wr_pend_q   <= 1'b0;
      rd_pend_q   <= 1'b0;
      addr_q      <= 32'h0000_0000;
    end else begin
      wr_pend_q <= 1'b0;
      if (rd_pend_q) begin
        hrdata_q    <= rd_mux;
        hreadyout_q <= 1'b1;
        rd_pend_q   <= 1'b0;
      end else if (req_take) begin
        addr_q      <= {haddr[31:2], 2'h0};
        wr_pend_q   <= wr_take;
        rd_pend_q   <= rd_take;
        hreadyout_q <= ~rd_take;
      end
    end
  end

  // register writes
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dig_ctrl_q <= `SPCR_RST_DIG_CTRL;
      anc_pend_q <= `SPCR_RST_AN_CTRL;
      anc_act_q  <= `SPCR_RST_AN_CTRL;
      advert_q   <= `SPCR_RST_ADVERT;
    end else if (wr_pend_q) begin
      case (addr_q)
        `SPCR_ADDR_DIG_CTRL: begin
          dig_ctrl_q <= hwdata[15:0];
        end
        `SPCR_ADDR_AN_CTRL: begin
          anc_pend_q <= hwdata[4:0];
        end
        `SPCR_ADDR_ADVERT: begin
          advert_q  <= hwdata[15:0];
          anc_act_q <= anc_pend_q;
        end
        default: begin
          advert_q <= advert_q;
        end
      endcase
    end
  end

  // pcs side controls
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_code_q  <= {`SPCR_CODE_W{1'b0}};
      rx_en_q    <= 1'b0;
      tx_en_q    <= 1'b0;
      pll_en_q   <= 1'b0;
      mode_q     <= `SPCR_MODE_SGMII;
      sgmii_q    <= 1'b0;
      serdes_q   <= 1'b0;
      role_q     <= 1'b0;
      link_set_q <= 1'b0;
      irq_q      <= 1'b0;
    end else begin
      rx_en_q  <= ~dig_ctrl_q[`SPCR_DIG_PSAVE_BIT];
      tx_en_q  <= ~dig_ctrl_q[`SPCR_DIG_PSAVE_BIT];
      pll_en_q <= 1'b1;
      if (dig_ctrl_q[`SPCR_DIG_PSAVE_BIT]) begin
        tx_code_q <= {`SPCR_CODE_W{1'b0}};
      end else if (dig_ctrl_q[`SPCR_DIG_LOOP_BIT]) begin
        tx_code_q <= rx_code;
      end else begin
        tx_code_q <= tx_code_in;
      end
      mode_q     <= anc_act_q[`SPCR_ANC_MODE_HI:`SPCR_ANC_MODE_LO];
      sgmii_q    <= (anc_act_q[`SPCR_ANC_MODE_HI:`SPCR_ANC_MODE_LO]
                     == `SPCR_MODE_SGMII);
      serdes_q   <= (anc_act_q[`SPCR_ANC_MODE_HI:`SPCR_ANC_MODE_LO]
                     == `SPCR_MODE_SERDES);
      role_q     <= anc_act_q[`SPCR_ANC_ROLE_BIT];
      link_set_q <= anc_act_q[`SPCR_ANC_LINK_BIT];
      irq_q      <= cplt_flag & anc_act_q[`SPCR_ANC_IRQEN_BIT];
    end
  end

  assign hreadyout       = hreadyout_q;
  assign hresp           = 1'b0;
  assign hrdata          = hrdata_q;
  assign tx_code         = tx_code_q;
  assign loopback_en     = dig_ctrl_q[`SPCR_DIG_LOOP_BIT];
  assign serdes_rx_en    = rx_en_q;
  assign serdes_tx_en    = tx_en_q;
  assign pll_en          = pll_en_q;
  assign pcs_mode        = mode_q;
  assign sgmii_mode      = sgmii_q;
  assign serdes_mode     = serdes_q;
  assign phy_side_role   = role_q;
  assign link_status_set = link_set_q;
  assign an_irq          = irq_q;

endmodule

// file: spcr_regs_properties.sv
// port assertions for the pcs control register bank
`timescale 1ns/100ps
`include "spcr_consts.vh"
module spcr_regs_chk (
  input wire       mclk,
  input wire       nrst,
  input wire       hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire       hwrite,
  input wire       hready,
  input wire       hreadyout,
  input wire       hresp,
  input wire [9:0] rx_code,
  input wire [9:0] tx_code,
  input wire       loopback_en,
  input wire       serdes_rx_en,
  input wire       serdes_tx_en,
  input wire       pll_en,
  input wire [1:0] pcs_mode,
  input wire       sgmii_mode,
  input wire       serdes_mode,
  input wire       phy_side_role,
  input wire       link_status_set,
  input wire       an_irq
);
  reg  [2:0] live_q;
  reg  [2:0] wr_age_q;
  reg  [2:0] adv_age_q;
  wire       tk = hsel && htrans[1] && hready;
  wire       live = (live_q == 3'h4);
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      live_q <= 3'h0;
      wr_age_q <= 3'h7;
      adv_age_q <= 3'h7;
    end else begin
      live_q <= live ? live_q : live_q + 3'h1;
      wr_age_q <= (tk && hwrite) ? 3'h0 : wr_age_q + {2'h0, wr_age_q != 3'h7};
      adv_age_q <= (tk && hwrite && haddr == `SPCR_ADDR_ADVERT) ? 3'h0 :
                   adv_age_q + {2'h0, adv_age_q != 3'h7};
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  a_resp_okay: assert property (hresp == 1'b0) else $error("hresp not okay");
  a_read_wait: assert property (tk && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_write_nowait: assert property (tk && hwrite |=> hreadyout) else $error("write stalled");
  a_tx_loop: assert property (live && loopback_en && $past(loopback_en) && serdes_tx_en
    && $past(serdes_tx_en) |-> tx_code == $past(rx_code)) else $error("loopback data wrong");
  a_psave_off: assert property (live && !serdes_tx_en && !$past(serdes_tx_en)
    |-> tx_code == 10'h000 && !serdes_rx_en && pll_en) else $error("power save wrong");
  a_mode_decode: assert property (live |-> sgmii_mode == (pcs_mode == `SPCR_MODE_SGMII)
    && serdes_mode == (pcs_mode == `SPCR_MODE_SERDES)) else $error("mode decode wrong");
  a_apply_gate: assert property (live && $changed({pcs_mode, phy_side_role, link_status_set})
    |-> adv_age_q <= 3'h4) else $error("control applied early");
  a_irq_sticky: assert property (live && $fell(an_irq) |-> wr_age_q <= 3'h4)
    else $error("interrupt dropped");
endmodule
bind spcr_regs spcr_regs_chk chk (.*);

// file: spcr_link_partner.sv
// link partner model: negotiation events, status levels, code groups
`timescale 1ns/100ps
module spcr_link_partner (
  input  wire       mclk,
  output reg        an_page_rx,
  output reg        an_done,
  output reg        lp_link_up,
  output reg  [1:0] lp_speed,
  output reg        lp_duplex,
  output reg  [9:0] rx_code
);
  initial begin
    {an_page_rx, an_done, lp_link_up, lp_speed, lp_duplex} = 5'h00;
    rx_code = 10'h000;
  end
  always @(posedge mclk) rx_code <= $urandom;
  task pulse(input pg);
    begin
      if (pg) an_page_rx <= 1'b1;
      else an_done <= 1'b1;
      @(posedge mclk);
      {an_page_rx, an_done} <= 2'h0;
    end
  endtask
  task set_link(input [3:0] s);
    {lp_link_up, lp_speed, lp_duplex} <= s;
  endtask
endmodule

// file: sgmii_pcs_control_regs_bench.sv
// self-checking bench for the pcs control register bank
`timescale 1ns/100ps
`include "spcr_consts.vh"
module sgmii_pcs_control_regs_bench;
  localparam [31:0] ADV = `SPCR_ADDR_ADVERT;
  localparam [31:0] EXP = `SPCR_ADDR_EXPANSION;
  localparam [31:0] DIG = `SPCR_ADDR_DIG_CTRL;
  localparam [31:0] ANC = `SPCR_ADDR_AN_CTRL;
  localparam [31:0] STS = `SPCR_ADDR_AN_STATUS;
  reg         mclk = 1'b0;
  reg         nrst = 1'b0;
  reg         hsel = 1'b0;
  reg  [31:0] haddr = 32'h0;
  reg  [1:0]  htrans = 2'h0;
  reg         hwrite = 1'b0;
  reg  [2:0]  hsize = 3'h2;
  reg  [31:0] hwdata = 32'h0;
  reg  [9:0]  tx_code_in = 10'h000;
  wire        hready;
  wire        hreadyout, hresp, an_page_rx, an_done, lp_link_up, lp_duplex;
  wire [31:0] hrdata;
  wire [1:0]  lp_speed, pcs_mode;
  wire [9:0]  rx_code, tx_code;
  wire        loopback_en, serdes_rx_en, serdes_tx_en, pll_en, sgmii_mode;
  wire        serdes_mode, phy_side_role, link_status_set, an_irq;
  integer     miscompares = 0;
  integer     samples_checked = 0;
  integer     cyc = 0;
  integer     i;
  reg  [31:0] rd;
  reg  [15:0] m_dig;
  reg  [4:0]  m_pend;
  reg  [4:0]  m_app = 5'h04;
  reg  [3:0]  m_lp;
  reg  [9:0]  rx_prev = 10'h000;
  reg  [9:0]  txin_prev = 10'h000;
  assign hready = hreadyout;
  spcr_regs dut (.*);
  spcr_link_partner lp (.*);
  always #10 mclk = ~mclk;
  always @(posedge mclk) begin
    tx_code_in <= $urandom;
    rx_prev <= rx_code;
    txin_prev <= tx_code_in;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares = miscompares + 1;
      close_out;
    end
  end
  task close_out;
    begin
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      samples_checked = samples_checked + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task xfer(input [31:0] a, input w, input [31:0] d);
    begin
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      @(posedge mclk);
      while (!hreadyout) @(posedge mclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge mclk);
      while (!hreadyout) @(posedge mclk);
      rd = hrdata;
    end
  endtask
  task rdchk(input string nm, input [31:0] a, input [31:0] e);
    begin
      xfer(a, 1'b0, 32'h0);
      chk(nm, e, rd);
    end
  endtask
  task apply(input [4:0] v);
    begin
      m_pend = v;
      xfer(ANC, 1'b1, {27'h0, v});
      xfer(ADV, 1'b1, $urandom & 32'hFFFF);
      m_app = v;
      repeat (3) @(posedge mclk);
    end
  endtask
  initial begin
    rd = $urandom(5);
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
    rdchk("dig_ctrl", DIG, 32'h2400);
    rdchk("an_ctrl", ANC, 32'h4);
    rdchk("expansion", EXP, 32'h0);
    rdchk("unmapped", 32'h00000100, 32'h0);
    chk("pcs_mode", 2'h2, pcs_mode);
    chk("pll_en", 1'b1, pll_en);
    $display("test reset done");
    for (i = 0; i < 4; i = i + 1) begin
      m_pend = $urandom;
      m_pend[2:1] = i;
      if (i == 0) m_pend[4:3] = 2'h3;
      if (i == 2) m_pend[3] = 1'b0;
      xfer(ANC, 1'b1, {27'h0, m_pend});
      rdchk("an_ctrl pend", ANC, {27'h0, m_pend});
      chk("mode held", m_app[2:1], pcs_mode);
      apply(m_pend);
      chk("pcs_mode", m_app[2:1], pcs_mode);
      chk("sgmii", m_app[2:1] == 2'h2, sgmii_mode);
      chk("serdes", m_app[2:1] == 2'h0, serdes_mode);
      chk("role", m_app[3], phy_side_role);
      chk("link set", m_app[4], link_status_set);
    end
    $display("test modes done");
    lp.pulse(1'b1);
    rdchk("page set", EXP, 32'h2);
    rdchk("page clear", EXP, 32'h0);
    fork
      xfer(EXP, 1'b0, 32'h0);
      begin
        @(posedge mclk);
        lp.pulse(1'b1);
      end
    join
    chk("page race rd", 32'h0, rd);
    rdchk("page set wins", EXP, 32'h2);
    rdchk("page clear again", EXP, 32'h0);
    $display("test page done");
    m_lp = $urandom;
    lp.set_link(m_lp);
    apply(5'h14);
    lp.pulse(1'b0);
    repeat (4) @(posedge mclk);
    chk("irq masked", 1'b0, an_irq);
    rdchk("status", STS, {27'h0, m_lp, 1'b1});
    apply(5'h15);
    xfer(STS, 1'b1, 32'h1);
    repeat (3) @(posedge mclk);
    chk("irq on", 1'b1, an_irq);
    xfer(STS, 1'b1, 32'h1E);
    repeat (3) @(posedge mclk);
    chk("irq off", 1'b0, an_irq);
    rdchk("status clr", STS, {27'h0, m_lp, 1'b0});
    $display("test interrupt done");
    m_dig = ($urandom & 16'hB7FF) | 16'h4000;
    xfer(DIG, 1'b1, {16'h0, m_dig});
    repeat (6) @(posedge mclk);
    chk("loopback", 1'b1, loopback_en);
    for (i = 0; i < 4; i = i + 1) begin
      @(posedge mclk);
      chk("tx loop", {22'h0, rx_prev}, {22'h0, tx_code});
    end
    rdchk("dig rd", DIG, {16'h0, m_dig});
    m_dig = ($urandom & 16'hB7FF) | 16'h0800;
    xfer(DIG, 1'b1, {16'h0, m_dig});
    repeat (6) @(posedge mclk);
    chk("rx off", 1'b0, serdes_rx_en);
    chk("tx off", 1'b0, serdes_tx_en);
    chk("tx zero", 10'h000, tx_code);
    chk("pll on", 1'b1, pll_en);
    xfer(DIG, 1'b1, 32'h2400);
    repeat (3) @(posedge mclk);
    chk("tx on", 1'b1, serdes_tx_en);
    for (i = 0; i < 4; i = i + 1) begin
      @(posedge mclk);
      chk("tx normal", {22'h0, txin_prev}, {22'h0, tx_code});
    end
    $display("test digital control done");
    close_out;
  end
endmodule
